// file: common/rhgs_map.svh
// Register offsets, field positions and reset values of the root hub global status block
`ifndef RHGS_MAP_SVH
`define RHGS_MAP_SVH
`define RHGS_ADDR_W 8
`define RHGS_OFF_GLOBAL_STATUS 8'h50
`define RHGS_OFF_PORT_POWER_MASK 8'h60
`define RHGS_OFF_IRQ_STATUS 8'h64
`define RHGS_OFF_IRQ_MASK 8'h68
`define RHGS_OFF_PORT_POWER 8'h6C
`define RHGS_OFF_CONFIG 8'h70
`define RHGS_BIT_CLR_WAKE 31
`define RHGS_BIT_OC_CHANGE 17
`define RHGS_BIT_SET_POWER 16
`define RHGS_BIT_WAKE_EN 15
`define RHGS_BIT_OC_FLAG 1
`define RHGS_BIT_CLR_POWER 0
`define RHGS_BIT_CFG_PER_PORT_POWER 0
`define RHGS_BIT_CFG_PER_PORT_OC 1
`define RHGS_IRQ_OC_CHANGE 0
`define RHGS_IRQ_RESUME 1
`define RHGS_IRQ_W 2
`define RHGS_RST_WORD 32'h0000_0000
`endif

// file: common/rhgs_pkg.sv
// Types shared by the root hub global status block
package rhgs_pkg;
    typedef enum logic [1:0] {
        RHGS_OPERATIONAL,
        RHGS_SUSPENDED,
        RHGS_RESUMING
    } rhgs_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rhgs_bus_t;
endpackage

// file: design/rhgs_global_status.sv
// Root hub global status and control register with global power strobes
// Notes on behaviour
// - Writing 1 to bit 31 clears the remote wake-up enable; writing 0 does nothing.
// - The overcurrent change flag at bit 17 is set whenever the global overcurrent flag changes.
// - Software clears the overcurrent change flag by writing 1; writing 0 leaves it.
// - Bit 16 always reads as 0.
// - In global power mode a 1 written to bit 16 powers every port; a 0 does nothing.
// - In per-port mode a 1 written to bit 16 powers only ports whose mask bit is clear.
// - With wake enable set, a connect change during suspend starts resume and a resume interrupt.
// - Writing 1 to bit 15 sets the wake enable, 0 leaves it, and a read returns it.
// - With global reporting, bit 1 reads 1 during overcurrent and 0 otherwise.
// - With per-port overcurrent protection, bit 1 always reads 0.
// - Bit 0 always reads as 0.
// - In global power mode a 1 written to bit 0 unpowers every port; a 0 does nothing.
// - In per-port mode a 1 written to bit 0 unpowers only ports whose mask bit is clear.
// - In per-port mode masked ports follow only per-port commands; unmasked ports follow global strobes.
`timescale 1ns/100ps
`include "rhgs_map.svh"
`default_nettype none
module rhgs_global_status #(
    parameter int NUM_PORTS = 2
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_ff,
    input wire logic overcurrent_in,
    input wire logic [NUM_PORTS-1:0] port_connect_change,
    input wire logic suspend_req,
    input wire logic resume_done,
    output logic [NUM_PORTS-1:0] port_power_ff,
    output logic resume_event_ff,
    output logic suspended_state_ff,
    output logic resuming_state_ff,
    output logic irq_ff
);
    rhgs_pkg::rhgs_bus_t bus;
    rhgs_pkg::rhgs_state_t state_ff;
    rhgs_pkg::rhgs_state_t nxt_state;
    logic remote_wakeup_enable_ff;
    logic global_overcurrent_change_ff;
    logic oc_prev_ff;
    logic [NUM_PORTS-1:0] port_power_mask_ff;
    logic per_port_power_ff;
    logic per_port_oc_ff;
    logic [`RHGS_IRQ_W-1:0] irq_status_ff;
    logic [`RHGS_IRQ_W-1:0] irq_mask_ff;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    wire wr_gs = bus.wr && hit(bus.addr, `RHGS_OFF_GLOBAL_STATUS);
    wire wr_mask = bus.wr && hit(bus.addr, `RHGS_OFF_PORT_POWER_MASK);
    wire wr_imask = bus.wr && hit(bus.addr, `RHGS_OFF_IRQ_MASK);
    wire wr_pp = bus.wr && hit(bus.addr, `RHGS_OFF_PORT_POWER);
    wire wr_cfg = bus.wr && hit(bus.addr, `RHGS_OFF_CONFIG);
    wire rd_istat = bus.rd && hit(bus.addr, `RHGS_OFF_IRQ_STATUS);
    wire rd_gs = bus.rd && hit(bus.addr, `RHGS_OFF_GLOBAL_STATUS);
    wire clr_wake = wr_gs && bus.wdata[`RHGS_BIT_CLR_WAKE];
    wire set_wake = wr_gs && bus.wdata[`RHGS_BIT_WAKE_EN];
    wire clr_occ = wr_gs && bus.wdata[`RHGS_BIT_OC_CHANGE];
    wire set_pwr = wr_gs && bus.wdata[`RHGS_BIT_SET_POWER];
    wire clr_pwr = wr_gs && bus.wdata[`RHGS_BIT_CLR_POWER];
    wire [NUM_PORTS-1:0] pp_wdata = bus.wdata[NUM_PORTS-1:0];
    wire [`RHGS_IRQ_W-1:0] nxt_imask = wr_imask ? bus.wdata[`RHGS_IRQ_W-1:0] : irq_mask_ff;
    // Reported overcurrent, forced low under per-port protection
    wire global_overcurrent_flag = overcurrent_in && !per_port_oc_ff;
    wire oc_edge = global_overcurrent_flag != oc_prev_ff;
    // Ports steered by global strobes
    wire [NUM_PORTS-1:0] global_sel = per_port_power_ff ?
        ~port_power_mask_ff : {NUM_PORTS{1'b1}};
    wire wake = (state_ff == rhgs_pkg::RHGS_SUSPENDED) && remote_wakeup_enable_ff
        && (|port_connect_change);
    wire [`RHGS_IRQ_W-1:0] irq_ev = {wake, oc_edge};
    wire [31:0] gs_word = {16'h0000, remote_wakeup_enable_ff, 13'h0000,
        global_overcurrent_flag, 1'b0} | {14'h0000, global_overcurrent_change_ff,
        1'b0, 16'h0000};

    logic [NUM_PORTS-1:0] nxt_power;
    always_comb
    begin
        nxt_power = port_power_ff;
        if (wr_pp && per_port_power_ff)
        begin
            nxt_power = (port_power_ff & ~port_power_mask_ff)
                | (pp_wdata & port_power_mask_ff);
        end
        if (clr_pwr)
        begin
            nxt_power = nxt_power & ~global_sel;
        end
        if (set_pwr)
        begin
            nxt_power = nxt_power | global_sel;
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            rhgs_pkg::RHGS_OPERATIONAL:
            begin
                if (suspend_req)
                begin
                    nxt_state = rhgs_pkg::RHGS_SUSPENDED;
                end
            end
            rhgs_pkg::RHGS_SUSPENDED:
            begin
                if (wake)
                begin
                    nxt_state = rhgs_pkg::RHGS_RESUMING;
                end
            end
            rhgs_pkg::RHGS_RESUMING:
            begin
                if (resume_done)
                begin
                    nxt_state = rhgs_pkg::RHGS_OPERATIONAL;
                end
            end
            default:
            begin
                nxt_state = rhgs_pkg::RHGS_OPERATIONAL;
            end
        endcase
    end

    logic [31:0] nxt_rdata;
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        case (bus.addr)
            `RHGS_OFF_GLOBAL_STATUS: nxt_rdata = gs_word;
            `RHGS_OFF_PORT_POWER_MASK: nxt_rdata[NUM_PORTS-1:0] = port_power_mask_ff;
            `RHGS_OFF_IRQ_STATUS: nxt_rdata[`RHGS_IRQ_W-1:0] = irq_status_ff;
            `RHGS_OFF_IRQ_MASK: nxt_rdata[`RHGS_IRQ_W-1:0] = irq_mask_ff;
            `RHGS_OFF_PORT_POWER: nxt_rdata[NUM_PORTS-1:0] = port_power_ff;
            `RHGS_OFF_CONFIG: nxt_rdata[1:0] = {per_port_oc_ff, per_port_power_ff};
            default: nxt_rdata = 32'h0000_0000;
        endcase
        if (!bus.rd)
        begin
            nxt_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            remote_wakeup_enable_ff <= 1'b0;
            global_overcurrent_change_ff <= 1'b0;
            oc_prev_ff <= 1'b0;
        end
        else
        begin
            // Clear has priority over set for the wake enable; an overcurrent edge has priority over clear
            if (clr_wake)
                remote_wakeup_enable_ff <= 1'b0;
            else if (set_wake)
                remote_wakeup_enable_ff <= 1'b1;
            if (oc_edge)
                global_overcurrent_change_ff <= 1'b1;
            else if (clr_occ)
                global_overcurrent_change_ff <= 1'b0;
            oc_prev_ff <= global_overcurrent_flag;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            port_power_ff <= '0;
            port_power_mask_ff <= '0;
            per_port_power_ff <= 1'b0;
            per_port_oc_ff <= 1'b0;
            irq_mask_ff <= '0;
        end
        else
        begin
            port_power_ff <= nxt_power;
            if (wr_mask)
                port_power_mask_ff <= reg_wdata[NUM_PORTS-1:0];
            if (wr_cfg)
            begin
                per_port_power_ff <= reg_wdata[`RHGS_BIT_CFG_PER_PORT_POWER];
                per_port_oc_ff <= reg_wdata[`RHGS_BIT_CFG_PER_PORT_OC];
            end
            if (wr_imask)
                irq_mask_ff <= reg_wdata[`RHGS_IRQ_W-1:0];
        end
    end

    logic [`RHGS_IRQ_W-1:0] nxt_istat;
    assign nxt_istat = (rd_istat ? '0 : irq_status_ff) | irq_ev;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_ff <= rhgs_pkg::RHGS_OPERATIONAL;
            irq_status_ff <= '0;
            irq_ff <= 1'b0;
            resume_event_ff <= 1'b0;
            suspended_state_ff <= 1'b0;
            resuming_state_ff <= 1'b0;
            reg_rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            state_ff <= nxt_state;
            irq_status_ff <= nxt_istat;
            irq_ff <= |(nxt_istat & nxt_imask);
            resume_event_ff <= wake;
            suspended_state_ff <= nxt_state == rhgs_pkg::RHGS_SUSPENDED;
            resuming_state_ff <= nxt_state == rhgs_pkg::RHGS_RESUMING;
            reg_rdata_ff <= nxt_rdata;
        end
    end

    occ_set_a: assert property (@(posedge clk_sys) disable iff (srst)
        oc_edge |=> global_overcurrent_change_ff)
        else $error("overcurrent change not set");
    occ_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
        clr_occ && !oc_edge |=> !global_overcurrent_change_ff)
        else $error("overcurrent change not cleared");
    occ_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
        global_overcurrent_change_ff && !clr_occ |=> global_overcurrent_change_ff)
        else $error("overcurrent change lost");
    wake_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
        clr_wake |=> !remote_wakeup_enable_ff)
        else $error("wake enable not cleared");
    wake_set_a: assert property (@(posedge clk_sys) disable iff (srst)
        set_wake && !clr_wake |=> remote_wakeup_enable_ff)
        else $error("wake enable not set");
    gs_read_a: assert property (@(posedge clk_sys) disable iff (srst)
        bus.rd && hit(bus.addr, `RHGS_OFF_GLOBAL_STATUS) |=>
        reg_rdata_ff[16] == 1'b0 && reg_rdata_ff[0] == 1'b0
        && reg_rdata_ff[15] == $past(remote_wakeup_enable_ff))
        else $error("global status read wrong");
    oc_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
        per_port_oc_ff |-> !global_overcurrent_flag)
        else $error("overcurrent flag not forced low");
    pwr_set_a: assert property (@(posedge clk_sys) disable iff (srst)
        set_pwr && !per_port_power_ff |=> &port_power_ff)
        else $error("global power on failed");
    pwr_clr_a: assert property (@(posedge clk_sys) disable iff (srst)
        clr_pwr && !set_pwr |=> (port_power_ff & global_sel) == '0)
        else $error("global power off failed");
    sequence wake_seq;
        wake ##1 (state_ff == rhgs_pkg::RHGS_RESUMING);
    endsequence
    resume_go_a: assert property (@(posedge clk_sys) disable iff (srst)
        wake |-> wake_seq)
        else $error("resume not entered");
    no_wake_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_ff == rhgs_pkg::RHGS_SUSPENDED && !remote_wakeup_enable_ff
        |=> state_ff != rhgs_pkg::RHGS_RESUMING)
        else $error("wake without enable");

    // Overcurrent change flag and indicator
    occ_race_a: assert property (@(posedge clk_sys) disable iff (srst)
        oc_edge && clr_occ |=> global_overcurrent_change_ff)
        else $error("overcurrent change lost to clear");
    occ_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
        !global_overcurrent_change_ff && !oc_edge |=> !global_overcurrent_change_ff)
        else $error("overcurrent change set without event");
    occ_read_a: assert property (@(posedge clk_sys) disable iff (srst)
        rd_gs |=>
        reg_rdata_ff[`RHGS_BIT_OC_CHANGE] == $past(global_overcurrent_change_ff))
        else $error("overcurrent change read wrong");
    oc_read_a: assert property (@(posedge clk_sys) disable iff (srst)
        rd_gs && !per_port_oc_ff |=>
        reg_rdata_ff[`RHGS_BIT_OC_FLAG] == $past(overcurrent_in))
        else $error("overcurrent flag read wrong");
    oc_off_a: assert property (@(posedge clk_sys) disable iff (srst)
        rd_gs && per_port_oc_ff |=>
        !reg_rdata_ff[`RHGS_BIT_OC_FLAG])
        else $error("overcurrent flag not zero in per-port mode");
    rsvd_read_a: assert property (@(posedge clk_sys) disable iff (srst)
        rd_gs |=>
        reg_rdata_ff[30:18] == 13'h0000 && reg_rdata_ff[14:2] == 13'h0000)
        else $error("reserved bits read nonzero");

    // Port power steering
    pwr_clr_g_a: assert property (@(posedge clk_sys) disable iff (srst)
        clr_pwr && !set_pwr && !per_port_power_ff |=> port_power_ff == '0)
        else $error("global power off left a port on");
    pwr_set_pp_a: assert property (@(posedge clk_sys) disable iff (srst)
        set_pwr && per_port_power_ff |=> (port_power_ff | port_power_mask_ff) == '1)
        else $error("unmasked port not powered");
    pwr_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
        wr_gs && !set_pwr && !clr_pwr |=> port_power_ff == $past(port_power_ff))
        else $error("power changed without a strobe");
    pwr_mask_keep_a: assert property (@(posedge clk_sys) disable iff (srst)
        (set_pwr || clr_pwr) && per_port_power_ff |=>
        (port_power_ff & port_power_mask_ff) == ($past(port_power_ff) & port_power_mask_ff))
        else $error("masked port followed a global strobe");
    pp_write_a: assert property (@(posedge clk_sys) disable iff (srst)
        wr_pp && per_port_power_ff |=>
        (port_power_ff & port_power_mask_ff) == ($past(pp_wdata) & port_power_mask_ff)
        && (port_power_ff & ~port_power_mask_ff)
        == ($past(port_power_ff) & ~port_power_mask_ff))
        else $error("per-port power write wrong");
    pp_ignore_a: assert property (@(posedge clk_sys) disable iff (srst)
        wr_pp && !per_port_power_ff |=> port_power_ff == $past(port_power_ff))
        else $error("per-port power write not ignored");

    // Wake-up and resume
    wake_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
        !set_wake && !clr_wake |=> remote_wakeup_enable_ff == $past(remote_wakeup_enable_ff))
        else $error("wake enable changed without a write");
    sequence resume_seq;
        resume_event_ff && state_ff == rhgs_pkg::RHGS_RESUMING;
    endsequence
    wake_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
        wake |=> resume_seq)
        else $error("resume event missing");
    wake_only_a: assert property (@(posedge clk_sys) disable iff (srst)
        !wake |=> !resume_event_ff)
        else $error("resume event without wake");
    resume_irq_a: assert property (@(posedge clk_sys) disable iff (srst)
        wake |=> irq_status_ff[`RHGS_IRQ_RESUME])
        else $error("resume interrupt not raised");

    // Interrupt, state outputs and read port
    occ_irq_a: assert property (@(posedge clk_sys) disable iff (srst)
        oc_edge |=> irq_status_ff[`RHGS_IRQ_OC_CHANGE])
        else $error("overcurrent interrupt not raised");
    irq_level_a: assert property (@(posedge clk_sys) disable iff (srst)
        irq_ff == |(irq_status_ff & irq_mask_ff))
        else $error("interrupt level wrong");
    state_out_a: assert property (@(posedge clk_sys) disable iff (srst)
        suspended_state_ff == (state_ff == rhgs_pkg::RHGS_SUSPENDED)
        && resuming_state_ff == (state_ff == rhgs_pkg::RHGS_RESUMING))
        else $error("state outputs wrong");
    rd_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
        !bus.rd |=> reg_rdata_ff == 32'h0000_0000)
        else $error("read data not idle");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the root hub global status block
`timescale 1ns/100ps
`include "rhgs_map.svh"
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] w;
        logic [31:0] r;
        logic [1:0] p;
    } rhgs_tb_row_t;
    localparam logic [7:0] A_GS = `RHGS_OFF_GLOBAL_STATUS;
    localparam logic [7:0] A_PM = `RHGS_OFF_PORT_POWER_MASK;
    localparam logic [7:0] A_IS = `RHGS_OFF_IRQ_STATUS;
    localparam logic [7:0] A_IM = `RHGS_OFF_IRQ_MASK;
    localparam logic [7:0] A_CF = `RHGS_OFF_CONFIG;
    localparam logic [7:0] A_PP = `RHGS_OFF_PORT_POWER;
    logic clk_sys;
    logic srst;
    rhgs_pkg::rhgs_bus_t bus;
    logic overcurrent_in;
    logic [1:0] pcc;
    logic suspend_req;
    logic resume_done;
    logic [31:0] reg_rdata_ff;
    logic [1:0] port_power_ff;
    logic resume_event_ff;
    logic suspended_state_ff;
    logic resuming_state_ff;
    logic irq_ff;
    int fail_count = 0;
    int n_compared = 0;
    int ev_cnt = 0;
    int e0;
    logic [31:0] d;
    rhgs_tb_row_t rows [19] = '{
        '{A_GS, 32'h0001_0000, 32'h0000_0000, 2'h3}, '{A_GS, 32'h0000_0001, 32'h0000_0000, 2'h0},
        '{A_GS, 32'h0000_8000, 32'h0000_8000, 2'h0}, '{A_GS, 32'h0000_0000, 32'h0000_8000, 2'h0},
        '{A_GS, 32'h0001_0000, 32'h0000_8000, 2'h3}, '{A_GS, 32'h0000_0000, 32'h0000_8000, 2'h3},
        '{A_GS, 32'h8000_0000, 32'h0000_0000, 2'h3}, '{A_GS, 32'h8000_8000, 32'h0000_0000, 2'h3},
        '{A_PM, 32'h0000_0001, 32'h0000_0000, 2'h3}, '{A_CF, 32'h0000_0001, 32'h0000_0000, 2'h3},
        '{A_GS, 32'h0000_0001, 32'h0000_0000, 2'h1}, '{A_GS, 32'h0001_0000, 32'h0000_0000, 2'h3},
        '{A_PM, 32'h0000_0002, 32'h0000_0000, 2'h3}, '{A_GS, 32'h0000_0001, 32'h0000_0000, 2'h2},
        '{A_PP, 32'h0000_0000, 32'h0000_0000, 2'h0}, '{A_PP, 32'h0000_0003, 32'h0000_0000, 2'h2},
        '{A_CF, 32'h0000_0000, 32'h0000_0000, 2'h2}, '{A_PP, 32'h0000_0000, 32'h0000_0000, 2'h2},
        '{A_GS, 32'h0000_0001, 32'h0000_0000, 2'h0}};
    rhgs_global_status #(.NUM_PORTS(2)) i_dut (.clk_sys(clk_sys), .srst(srst),
        .reg_addr(bus.addr), .reg_wdata(bus.wdata), .reg_wr(bus.wr), .reg_rd(bus.rd),
        .reg_rdata_ff(reg_rdata_ff), .overcurrent_in(overcurrent_in),
        .port_connect_change(pcc), .suspend_req(suspend_req), .resume_done(resume_done),
        .port_power_ff(port_power_ff), .resume_event_ff(resume_event_ff),
        .suspended_state_ff(suspended_state_ff), .resuming_state_ff(resuming_state_ff),
        .irq_ff(irq_ff));
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (resume_event_ff === 1'b1)
            ev_cnt <= ev_cnt + 1;
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 q = reg_rdata_ff;
        @(posedge clk_sys);
    endtask
    task automatic pulse(input int which);
        if (which == 0) suspend_req <= 1'b1;
        else if (which == 1) resume_done <= 1'b1;
        else pcc <= 2'h2;
        @(posedge clk_sys);
        suspend_req <= 1'b0;
        resume_done <= 1'b0;
        pcc <= 2'h0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic complete_run;
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        fail_count++;
        complete_run();
    end
    initial
    begin
        bus = '0;
        srst = 1'b1;
        overcurrent_in = 1'b0;
        pcc = 2'h0;
        suspend_req = 1'b0;
        resume_done = 1'b0;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        `CHK({reg_rdata_ff, port_power_ff, irq_ff, suspended_state_ff}, 36'h0);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            rd(A_GS, d);
            `CHK(d, rows[i].r);
            `CHK(port_power_ff, rows[i].p);
        end
        overcurrent_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(A_GS, d);
        `CHK(d, 32'h0002_0002);
        `CHK(irq_ff, 1'b0);
        wr(A_GS, 32'h0000_0000);
        rd(A_GS, d);
        `CHK(d, 32'h0002_0002);
        wr(A_GS, 32'h0002_0000);
        rd(A_GS, d);
        `CHK(d, 32'h0000_0002);
        overcurrent_in <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(A_GS, d);
        `CHK(d, 32'h0002_0000);
        overcurrent_in <= 1'b1;
        wr(A_GS, 32'h0002_0000);
        rd(A_GS, d);
        `CHK(d, 32'h0002_0002);
        wr(A_IM, 32'h0000_0003);
        repeat (3) @(posedge clk_sys);
        `CHK(irq_ff, 1'b1);
        rd(A_IS, d);
        `CHK(d, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        `CHK(irq_ff, 1'b0);
        overcurrent_in <= 1'b1;
        wr(A_CF, 32'h0000_0002);
        repeat (4) @(posedge clk_sys);
        rd(A_GS, d);
        `CHK(d[1], 1'b0);
        wr(A_CF, 32'h0000_0000);
        repeat (4) @(posedge clk_sys);
        rd(A_GS, d);
        `CHK(d[1], 1'b1);
        overcurrent_in <= 1'b0;
        wr(A_GS, 32'h0000_8000);
        pulse(0);
        `CHK(suspended_state_ff, 1'b1);
        e0 = ev_cnt;
        pulse(2);
        `CHK(ev_cnt - e0, 1);
        `CHK(resuming_state_ff, 1'b1);
        rd(A_IS, d);
        `CHK(d[1], 1'b1);
        pulse(1);
        `CHK(resuming_state_ff, 1'b0);
        wr(A_GS, 32'h8000_0000);
        pulse(0);
        pulse(2);
        `CHK(ev_cnt - e0, 1);
        `CHK({suspended_state_ff, resuming_state_ff}, 2'h2);
        wr(8'h7C, 32'hFFFF_FFFF);
        rd(8'h7C, d);
        `CHK(d, 32'h0000_0000);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        rd(A_GS, d);
        `CHK(d, 32'h0000_0000);
        `CHK({port_power_ff, irq_ff, suspended_state_ff, resuming_state_ff}, 5'h00);
        complete_run();
    end
endmodule
`default_nettype wire
